// ===== hw/plbs_pkg.sv
// package: constants and carrier types for the pll lock and boot strap block
package plbs_pkg;
    localparam logic [7:0]  PART_ID_ADDR     = 8'hC2;
    localparam logic [7:0]  PLL_CTRL_ADDR    = 8'hD7;
    localparam int          PLL_LOCK_BIT     = 6;
    localparam int          OSC_PD_BIT       = 4;
    // family code is arbitrary, not a real part's
    localparam logic [3:0]  FAMILY_CODE      = 4'hA;
    localparam logic [3:0]  ID_LOW_NIBBLE    = 4'h0;
    localparam logic [7:0]  PLL_CTRL_RESET   = 8'h00;
    localparam int          PLL_MULT         = 384;
    localparam int          XTAL_HZ          = 32768;
    localparam int          CLK_HZ           = 20000000;
    localparam int          LOCK_TIME_US     = 1000;
    localparam int          OSC_START_MS     = 150;
    localparam int          LOCK_CYCLES      = CLK_HZ / 1000000 * LOCK_TIME_US;
    localparam int          OSC_CYCLES       = CLK_HZ / 1000 * OSC_START_MS;
    localparam int          CNT_W            = 22;

    typedef enum logic [3:0] {
        PLBS_LOCKED  = 4'h1,
        PLBS_OSC_WT  = 4'h2,
        PLBS_LOCK_WT = 4'h4,
        PLBS_DOWN    = 4'h8
    } plbs_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } plbs_sfr_req_t;
endpackage

// ===== hw/plbs_strap.sv
// strap capture of the fetch strobe pin at reset release
`timescale 1ns/100ps
`default_nettype none
module plbs_strap (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic strobe_in_i,
    output logic      download_mode_o,
    output logic      strap_done_o
);
    logic dl_r;
    logic dl_nxt;
    logic done_r;
    logic done_nxt;

    // one sample on the first clock after release; pin ignored afterwards
    always_comb begin
        dl_nxt   = dl_r;
        done_nxt = done_r;
        if (!done_r) begin
            dl_nxt   = !strobe_in_i;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dl_r   <= 1'b0;
            done_r <= 1'b0;
        end else begin
            dl_r   <= dl_nxt;
            done_r <= done_nxt;
        end
    end

    assign download_mode_o = dl_r;
    assign strap_done_o    = done_r;
endmodule
`default_nettype wire

// ===== hw/plbs_top.sv
// top: pll lock timing, part id register, boot strap mode
// Behaviour
// - pll control register bit 6 shows lock for software polling.
// - after wake with oscillator running, lock returns after about 1 ms.
// - oscillator stopped in power-down adds about 150 ms before lock.
// - high-speed clock is 384 times the 32.768 kHz crystal.
// - read-only part id register at C2H; writes ignored.
// - part id upper nibble is family code, lower nibble unspecified.
// - fetch strobe pin is an output, sampled once at reset release.
// - strobe low at reset end selects serial download mode.
// - strobe not low at reset end selects normal run mode.
`timescale 1ns/100ps
`default_nettype none
module plbs_top #(
    parameter int LOCK_CYC = plbs_pkg::LOCK_CYCLES,
    parameter int OSC_CYC  = plbs_pkg::OSC_CYCLES
) (
    input  wire logic                   clock_i,
    input  wire logic                   reset_i,
    input  wire plbs_pkg::plbs_sfr_req_t sfr_req_i,
    output logic [7:0]                  sfr_rdata_o,
    output logic                        sfr_hit_o,
    input  wire logic                   power_down_i,
    input  wire logic                   wake_i,
    input  wire logic                   strobe_in_i,
    input  wire logic                   strobe_drive_i,
    output logic                        strobe_out_o,
    output logic                        strobe_oe_n_o,
    output logic                        download_mode_o,
    output logic                        pll_locked_o
);
    plbs_pkg::plbs_state_t     st_r;
    plbs_pkg::plbs_state_t     st_nxt;
    logic [plbs_pkg::CNT_W-1:0] cnt_r;
    logic [plbs_pkg::CNT_W-1:0] cnt_nxt;
    logic [7:0]                ctrl_r;
    logic [7:0]                ctrl_nxt;
    logic [7:0]                rdata_r;
    logic [7:0]                rdata_nxt;
    logic                      strap_done;
    logic                      lock_bit;

    // decode, read-back and terminal-count helpers
    logic                      osc_pd;
    logic                      osc_done;
    logic                      lock_done;
    logic                      hit_id;
    logic                      hit_ctrl;
    logic                      wr_ctrl;
    logic [7:0]                ctrl_view;
    logic [7:0]                id_value;

    // pll modelled as a timer; multiplier kept for reference
    localparam int PLL_HZ = plbs_pkg::PLL_MULT * plbs_pkg::XTAL_HZ;

    plbs_strap u_strap (
        .clock_i         (clock_i),
        .reset_i         (reset_i),
        .strobe_in_i     (strobe_in_i),
        .download_mode_o (download_mode_o),
        .strap_done_o    (strap_done)
    );

    // pin released until the strap is taken, then driven as output
    assign strobe_oe_n_o = !strap_done;
    assign strobe_out_o  = strobe_drive_i;

    // terminal counts compare with count minus one, so each wait lasts exactly its parameter
    // limitation: CNT_W must hold OSC_CYC, a larger wait would be cut short by the cast
    assign osc_pd    = ctrl_r[plbs_pkg::OSC_PD_BIT];
    assign osc_done  = (cnt_r >= plbs_pkg::CNT_W'(OSC_CYC - 1));
    assign lock_done = (cnt_r >= plbs_pkg::CNT_W'(LOCK_CYC - 1));

    // lock sequencer, one-hot:
    //   reset          -> oscillator wait -> lock wait -> locked
    //   locked         -> down on a power-down request
    //   down with wake -> oscillator wait if the oscillator was stopped, else lock wait
    // the core runs on through both waits; only the lock bit says when the clock is good
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            plbs_pkg::PLBS_LOCKED: begin
                if (power_down_i) begin
                    st_nxt = plbs_pkg::PLBS_DOWN;
                end
            end
            plbs_pkg::PLBS_DOWN: begin
                if (wake_i) begin
                    if (osc_pd) begin
                        st_nxt = plbs_pkg::PLBS_OSC_WT;
                    end else begin
                        st_nxt = plbs_pkg::PLBS_LOCK_WT;
                    end
                end
            end
            plbs_pkg::PLBS_OSC_WT: begin
                if (osc_done) begin
                    st_nxt = plbs_pkg::PLBS_LOCK_WT;
                end
            end
            plbs_pkg::PLBS_LOCK_WT: begin
                if (lock_done) begin
                    st_nxt = plbs_pkg::PLBS_LOCKED;
                end
            end
            // a stray code falls back to a full lock wait rather than claiming lock
            default: begin
                st_nxt = plbs_pkg::PLBS_LOCK_WT;
            end
        endcase
    end

    // wait counter runs only in the two wait states and restarts at every phase change
    always_comb begin
        cnt_nxt = '0;
        case (st_r)
            plbs_pkg::PLBS_OSC_WT: begin
                if (!osc_done) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            plbs_pkg::PLBS_LOCK_WT: begin
                if (!lock_done) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                cnt_nxt = '0;
            end
        endcase
    end

    // reset enters the oscillator wait: a power-on looks like a cold crystal start
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r <= plbs_pkg::PLBS_OSC_WT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // no enable needed: the next count already rests at zero outside the waits
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign lock_bit     = (st_r == plbs_pkg::PLBS_LOCKED);
    assign pll_locked_o = lock_bit;

    // register decode; only the two mapped addresses answer
    // sfr_hit_o is address decode only and does not qualify a transfer
    assign hit_id    = (sfr_req_i.addr == plbs_pkg::PART_ID_ADDR);
    assign hit_ctrl  = (sfr_req_i.addr == plbs_pkg::PLL_CTRL_ADDR);
    assign wr_ctrl   = sfr_req_i.wr && hit_ctrl;
    assign sfr_hit_o = hit_id || hit_ctrl;

    // id byte is wired, so a write to it has nothing to land in
    // low nibble carries no meaning for software; it is tied to a fixed value
    assign id_value = {plbs_pkg::FAMILY_CODE, plbs_pkg::ID_LOW_NIBBLE};

    // read-back view: lock bit comes live from the sequencer, not from storage
    for (genvar i = 0; i < 8; i++) begin : g_ctrl_view
        if (i == plbs_pkg::PLL_LOCK_BIT) begin : g_lock
            assign ctrl_view[i] = lock_bit;
        end else begin : g_store
            assign ctrl_view[i] = ctrl_r[i];
        end
    end

    // control byte; the stored lock bit stays zero so it can never mask the live one
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt                         = sfr_req_i.wdata;
            ctrl_nxt[plbs_pkg::PLL_LOCK_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_r <= plbs_pkg::PLL_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // read data holds until the next read, so a slow poll loop sees a steady byte
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_req_i.rd) begin
            case (sfr_req_i.addr)
                plbs_pkg::PART_ID_ADDR: begin
                    rdata_nxt = id_value;
                end
                plbs_pkg::PLL_CTRL_ADDR: begin
                    rdata_nxt = ctrl_view;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // registered read data keeps the output clear of the address decode path
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata_o = rdata_r;
endmodule
`default_nettype wire

// ===== test/plbs_jumper.sv
// model: download jumper and pull-up on the fetch strobe pin
`timescale 1ns/100ps
`default_nettype none
module plbs_jumper (
    input  wire logic jumper_i,
    input  wire logic drive_i,
    input  wire logic oe_n_i,
    output logic      pin_o
);
    // released pin rests at the pull-up; only the jumper may pull it low
    assign pin_o = !oe_n_i ? drive_i : !jumper_i;
endmodule
`default_nettype wire

// ===== test/plbs_chk.sv
// checker: port-level properties of the lock and strap top
`timescale 1ns/100ps
`default_nettype none
module plbs_chk #(
    parameter int LOCK_CYC = 5,
    parameter int OSC_CYC  = 7
) (
    input wire logic                    clock_i,
    input wire logic                    reset_i,
    input wire plbs_pkg::plbs_sfr_req_t sfr_req_i,
    input wire logic [7:0]              sfr_rdata_o,
    input wire logic                    power_down_i,
    input wire logic                    wake_i,
    input wire logic                    strobe_in_i,
    input wire logic                    download_mode_o,
    input wire logic                    pll_locked_o
);
    localparam int WMAX = OSC_CYC + LOCK_CYC + 4;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    chk_part_id_read: assert property (
        sfr_req_i.rd && sfr_req_i.addr == plbs_pkg::PART_ID_ADDR
        |=> sfr_rdata_o == {plbs_pkg::FAMILY_CODE, plbs_pkg::ID_LOW_NIBBLE}) else $error("part id read wrong");
    chk_lock_bit_read: assert property (
        sfr_req_i.rd && sfr_req_i.addr == plbs_pkg::PLL_CTRL_ADDR && pll_locked_o && !power_down_i
        |=> sfr_rdata_o[6]) else $error("lock bit not read as set");
    chk_strap_mode: assert property (
        !reset_i && $past(reset_i) |=> download_mode_o == !$past(strobe_in_i)) else $error("strap mode wrong");
    chk_mode_hold: assert property (
        !$past(reset_i) && !$past(reset_i, 2) |-> $stable(download_mode_o)) else $error("mode changed after strap");
    chk_reset_lock: assert property (
        !reset_i && $past(reset_i) |-> !pll_locked_o [*8]) else $error("lock too early after reset");
    chk_wake_low: assert property (
        wake_i && !pll_locked_o |=> !pll_locked_o [*4]) else $error("lock too early after wake");
    chk_wake_bound: assert property (
        wake_i && !pll_locked_o |-> ##[1:WMAX] pll_locked_o) else $error("lock never regained");
    chk_pd_drop: assert property (
        power_down_i && pll_locked_o |=> !pll_locked_o) else $error("lock held in power-down");
endmodule
bind plbs_top plbs_chk #(.LOCK_CYC(LOCK_CYC), .OSC_CYC(OSC_CYC)) u_chk (.clock_i(clock_i), .reset_i(reset_i),
    .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .power_down_i(power_down_i), .wake_i(wake_i),
    .strobe_in_i(strobe_in_i), .download_mode_o(download_mode_o), .pll_locked_o(pll_locked_o));
`default_nettype wire

// ===== test/testbench.sv
// testbench: strap, part id and lock timing scenarios
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int L = 5;
    localparam int O = 7;
    logic clock_i = 0, reset_i = 1, pd = 0, wk = 0, drv = 1, jmp = 0;
    plbs_pkg::plbs_sfr_req_t req = '0;
    logic [7:0] rdata;
    logic hit, hit_seen, sout, oe_n, dl, lock, pin;
    int n_fail = 0, n_tests = 0;
    plbs_top #(.LOCK_CYC(L), .OSC_CYC(O)) uut (.clock_i(clock_i), .reset_i(reset_i), .sfr_req_i(req),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .power_down_i(pd), .wake_i(wk), .strobe_in_i(pin),
        .strobe_drive_i(drv), .strobe_out_o(sout), .strobe_oe_n_o(oe_n), .download_mode_o(dl), .pll_locked_o(lock));
    plbs_jumper u_jmp (.jumper_i(jmp), .drive_i(sout), .oe_n_i(oe_n), .pin_o(pin));
    initial forever #25 clock_i = ~clock_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clock_i);
        hit_seen = hit;
        @(negedge clock_i);
        req = '0;
    endtask
    // software side polls lock before timing work
    task automatic wait_lock(output int n);
        n = 0;
        while (lock !== 1'b1 && n < 100) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic t_boot(input logic j);
        int n;
        jmp = j;
        reset_i = 1;
        repeat (8) @(negedge clock_i);
        chk(oe_n, 1);
        reset_i = 0;
        repeat (2) @(negedge clock_i);
        chk(dl, j);
        chk(oe_n, 0);
        chk(lock, 0);
        drv = 0;
        #1 chk(sout, 0);
        wait_lock(n);
        chk(n >= O + L - 4 && n <= O + L + 2, 1);
        sfr(0, plbs_pkg::PLL_CTRL_ADDR, 8'h00);
        chk(rdata[6], 1);
        chk(hit_seen, 1);
        drv = 1;
        $display("boot test done");
    endtask
    task automatic t_id;
        sfr(0, plbs_pkg::PART_ID_ADDR, 8'h00);
        chk(rdata, {plbs_pkg::FAMILY_CODE, plbs_pkg::ID_LOW_NIBBLE});
        chk(hit_seen, 1);
        sfr(1, plbs_pkg::PART_ID_ADDR, 8'h5A);
        sfr(0, plbs_pkg::PART_ID_ADDR, 8'h00);
        chk(rdata, {plbs_pkg::FAMILY_CODE, plbs_pkg::ID_LOW_NIBBLE});
        sfr(0, 8'h00, 8'h00);
        chk(rdata, 8'h00);
        chk(hit_seen, 0);
        $display("id test done");
    endtask
    task automatic t_wake(input logic osc);
        int n;
        sfr(1, plbs_pkg::PLL_CTRL_ADDR, {3'h0, osc, 4'h0});
        @(negedge clock_i);
        pd = 1;
        @(negedge clock_i);
        pd = 0;
        chk(lock, 0);
        wk = 1;
        @(negedge clock_i);
        wk = 0;
        wait_lock(n);
        chk(n >= (osc ? O : 0) + L - 1 && n <= (osc ? O : 0) + L + 3, 1);
        sfr(0, plbs_pkg::PLL_CTRL_ADDR, 8'h00);
        chk(rdata, {3'h2, osc, 4'h0});
        $display("wake test done");
    endtask
    task automatic complete_run;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        t_boot(1);
        t_boot(0);
        t_id;
        t_wake(0);
        t_wake(1);
        complete_run;
    end
    initial begin
        #(3000 * 50);
        n_fail++;
        complete_run;
    end
endmodule
`default_nettype wire
